// ### rtl/ssa_regs.svh
`ifndef SSA_REGS_SVH
`define SSA_REGS_SVH
`define SSA_ADDR_W          11
`define SSA_DATA_W          8
`define SSA_DEPTH           2048
`define SSA_CLK_PERIOD_NS   10
`define SSA_ADDR_ACCESS_NS  45
`define SSA_SEL_ACCESS_NS   45
`define SSA_DRV_ACCESS_NS   20
`define SSA_DATA_SETUP_NS   15
`define SSA_WPULSE_NS       30
`define SSA_FLOAT_NS        15
`define SSA_GRACE_US        1
`define SSA_RECALL_US       550
`define SSA_SAVE_MS         10
`define SSA_ACC_CYC         ((`SSA_ADDR_ACCESS_NS + `SSA_CLK_PERIOD_NS - 1) / `SSA_CLK_PERIOD_NS)
`define SSA_WP_CYC          ((`SSA_WPULSE_NS + `SSA_CLK_PERIOD_NS - 1) / `SSA_CLK_PERIOD_NS)
`define SSA_GRACE_CYC       ((`SSA_GRACE_US * 1000) / `SSA_CLK_PERIOD_NS)
`define SSA_RECALL_CYC      ((`SSA_RECALL_US * 1000) / `SSA_CLK_PERIOD_NS)
`define SSA_SAVE_CYC        ((`SSA_SAVE_MS * 1000000) / `SSA_CLK_PERIOD_NS)
`endif

// ### rtl/ssa_pkg.sv
package ssa_pkg;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_RSET  = 6'h02,
        ST_RWAIT = 6'h04,
        ST_WSET  = 6'h08,
        ST_WPULS = 6'h10,
        ST_WEND  = 6'h20
    } ssa_state_t;
endpackage

// ### rtl/ssa_sync.sv
`timescale 1ns/1ps
module ssa_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ssa_sync_state_t;

    ssa_sync_state_t s_reg;
    ssa_sync_state_t s_next;

    // only the second stage leaves this module
    always_comb begin
        s_next        = s_reg;
        s_next.meta   = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule // ssa_sync

// ### rtl/ssa_host.sv
`timescale 1ns/1ps
`include "ssa_regs.svh"
// Behaviour
// - host holds address stable through write
// - byte stored at terminating rising edge
// - host keeps drive strobe high writing
// - host keeps write inactive at recall end
module ssa_host (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic [`SSA_ADDR_W-1:0] req_addr,
    input  wire logic [`SSA_DATA_W-1:0] req_wdata,
    output logic                        req_ready,
    output logic                        rsp_valid,
    output logic      [`SSA_DATA_W-1:0] rsp_rdata,
    input  wire logic                   power_ok,
    output logic                        mem_busy,
    output logic                        sel_n,
    output logic                        drive_n,
    output logic                        write_n,
    output logic      [`SSA_ADDR_W-1:0] addr_in,
    input  wire logic [`SSA_DATA_W-1:0] data_io_i,
    output logic      [`SSA_DATA_W-1:0] data_io_o,
    output logic      [`SSA_DATA_W-1:0] data_io_oe_n
);
    localparam int ACC_CYC  = `SSA_ACC_CYC;
    localparam int WP_CYC   = `SSA_WP_CYC;
    localparam int BUSY_CYC = `SSA_GRACE_CYC + `SSA_SAVE_CYC;
    localparam int REC_CYC  = `SSA_RECALL_CYC;

    typedef struct packed {
        ssa_pkg::ssa_state_t              st;
        logic [23:0]                      cnt;
        logic [23:0]                      busy;
        logic                             pwr_q;
        logic                             req_ready;
        logic                             rsp_valid;
        logic [`SSA_DATA_W-1:0]           rdata;
        logic                             sel_n;
        logic                             drive_n;
        logic                             write_n;
        logic [`SSA_ADDR_W-1:0]           addr;
        logic [`SSA_DATA_W-1:0]           wdata;
        logic                             oe_n;
        logic                             busy_flag;
    } ssa_host_state_t;

    ssa_host_state_t s_reg;
    ssa_host_state_t s_next;
    logic [`SSA_DATA_W-1:0] din_sync;
    logic                   pwr_sync;

    ////////////////////////////////////////////////////////////////////////////
    ssa_sync #(.W(`SSA_DATA_W)) u_dsync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (data_io_i),
        .q   (din_sync)
    );
    ssa_sync #(.W(1)) u_psync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (power_ok),
        .q   (pwr_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next           = s_reg;
        s_next.rsp_valid = 1'b0;
        s_next.pwr_q     = pwr_sync;
        if (s_reg.busy != 24'h000000) begin
            s_next.busy = s_reg.busy - 24'h000001;
        end
        // supply edges: fall allows grace + save, rise waits for recall
        if (s_reg.pwr_q && !pwr_sync) begin
            s_next.busy = 24'(BUSY_CYC);
        end else if (!s_reg.pwr_q && pwr_sync) begin
            s_next.busy = 24'(REC_CYC);
        end
        s_next.busy_flag = s_next.busy != 24'h000000;
        s_next.req_ready = 1'b0;
        unique case (s_reg.st)
            ssa_pkg::ST_IDLE: begin
                s_next.sel_n   = 1'b1;
                s_next.drive_n = 1'b1;
                s_next.write_n = 1'b1;
                s_next.oe_n    = 1'b1;
                // no access below trip or while device is busy
                if (req_valid && pwr_sync && s_reg.busy == 24'h000000 && !s_reg.req_ready) begin
                    s_next.req_ready = 1'b1;
                    s_next.addr      = req_addr;
                    s_next.wdata     = req_wdata;
                    s_next.cnt       = 24'h000000;
                    s_next.st        = req_write ? ssa_pkg::ST_WSET : ssa_pkg::ST_RSET;
                end
            end
            ssa_pkg::ST_RSET: begin
                s_next.sel_n   = 1'b0;
                s_next.drive_n = 1'b0;
                s_next.st      = ssa_pkg::ST_RWAIT;
            end
            ssa_pkg::ST_RWAIT: begin
                s_next.cnt = s_reg.cnt + 24'h000001;
                // two extra cycles cover the input synchroniser
                if (s_reg.cnt == 24'(ACC_CYC + 2)) begin
                    s_next.rdata     = din_sync;
                    s_next.rsp_valid = 1'b1;
                    s_next.sel_n     = 1'b1;
                    s_next.drive_n   = 1'b1;
                    s_next.st        = ssa_pkg::ST_IDLE;
                end
            end
            ssa_pkg::ST_WSET: begin
                // write falls before select, so device never drives
                s_next.write_n = 1'b0;
                s_next.drive_n = 1'b1;
                s_next.oe_n    = 1'b0;
                s_next.st      = ssa_pkg::ST_WPULS;
            end
            ssa_pkg::ST_WPULS: begin
                s_next.sel_n = 1'b0;
                s_next.cnt   = s_reg.cnt + 24'h000001;
                if (s_reg.cnt == 24'(WP_CYC)) begin
                    s_next.write_n = 1'b1;
                    s_next.st      = ssa_pkg::ST_WEND;
                end
            end
            ssa_pkg::ST_WEND: begin
                // address and data held one cycle past the edge
                s_next.sel_n     = 1'b1;
                s_next.oe_n      = 1'b1;
                s_next.rsp_valid = 1'b1;
                s_next.st        = ssa_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg         <= '0;
            s_reg.st      <= ssa_pkg::ST_IDLE;
            s_reg.sel_n   <= 1'b1;
            s_reg.drive_n <= 1'b1;
            s_reg.write_n <= 1'b1;
            s_reg.oe_n    <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign req_ready    = s_reg.req_ready;
    assign rsp_valid    = s_reg.rsp_valid;
    assign rsp_rdata    = s_reg.rdata;
    assign mem_busy     = s_reg.busy_flag;
    assign sel_n        = s_reg.sel_n;
    assign drive_n      = s_reg.drive_n;
    assign write_n      = s_reg.write_n;
    assign addr_in      = s_reg.addr;
    assign data_io_o    = s_reg.wdata;
    assign data_io_oe_n = {`SSA_DATA_W{s_reg.oe_n}};

    ////////////////////////////////////////////////////////////////////////////
    AST_READ_STROBES: assert property (@(posedge clk) disable iff (rst)
        (s_reg.st == ssa_pkg::ST_RWAIT) |-> (!sel_n && !drive_n && write_n))
        else $error("read strobes wrong");
    AST_WRITE_NO_DRIVE: assert property (@(posedge clk) disable iff (rst)
        (!write_n) |-> drive_n)
        else $error("drive low during write");
    AST_WRITE_BEFORE_SEL: assert property (@(posedge clk) disable iff (rst)
        $fell(sel_n) && (s_reg.st == ssa_pkg::ST_WPULS) |-> !write_n)
        else $error("select fell before write");
    AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (rst || !ce)
        (!sel_n && !write_n) |=> $stable(addr_in))
        else $error("address moved in write");
    AST_NO_ACCESS_BUSY: assert property (@(posedge clk) disable iff (rst)
        (mem_busy && s_reg.st == ssa_pkg::ST_IDLE) |=> (s_reg.st == ssa_pkg::ST_IDLE && !req_ready))
        else $error("access during busy");
    AST_NO_WRITE_LOW: assert property (@(posedge clk) disable iff (rst)
        $rose(s_reg.req_ready) |-> $past(pwr_sync))
        else $error("access below trip");
    AST_READ_LEN: assert property (@(posedge clk) disable iff (rst || !ce)
        (s_reg.st == ssa_pkg::ST_RSET) |=> (s_reg.st == ssa_pkg::ST_RWAIT)[*8])
        else $error("read too short");
    AST_WRITE_END: assert property (@(posedge clk) disable iff (rst || !ce)
        $rose(write_n) && (s_reg.st == ssa_pkg::ST_WEND) |-> !sel_n && $stable(data_io_o))
        else $error("write end order");
    AST_RECALL_WAIT: assert property (@(posedge clk) disable iff (rst || !ce)
        $rose(s_reg.pwr_q) |=> mem_busy)
        else $error("no recall wait");
    AST_SAVE_WINDOW: assert property (@(posedge clk) disable iff (rst)
        $fell(s_reg.pwr_q) |-> (s_reg.busy == 24'(BUSY_CYC)))
        else $error("save window not loaded");
    AST_RECALL_WINDOW: assert property (@(posedge clk) disable iff (rst)
        $rose(s_reg.pwr_q) |-> (s_reg.busy == 24'(REC_CYC)))
        else $error("recall window not loaded");
    AST_IDLE_STROBES: assert property (@(posedge clk) disable iff (rst)
        (s_reg.st == ssa_pkg::ST_IDLE) |-> (sel_n && drive_n && write_n))
        else $error("strobe low while idle");
    AST_BUS_DRIVE_WRITE: assert property (@(posedge clk) disable iff (rst)
        (!data_io_oe_n[0]) |-> drive_n)
        else $error("bus driven with drive low");
endmodule // ssa_host

// ### sim/ssa_device_model.sv
`timescale 1ns/1ps
`include "ssa_regs.svh"
module ssa_device_model (
    input  wire logic       sel_n,
    input  wire logic       drive_n,
    input  wire logic       write_n,
    input  wire logic [10:0] addr_in,
    input  wire logic [7:0] data_io_o,
    input  wire logic [7:0] data_io_oe_n,
    input  wire logic       power_ok,
    output wire logic [7:0] data_io_i
);
    logic [7:0] mem    [0:`SSA_DEPTH-1];
    logic [7:0] shadow [0:`SSA_DEPTH-1];
    logic [7:0] dq;
    logic       dirty;
    logic       recall_req;
    logic       busy;
    int         seq;
    wire        rd = !sel_n && !drive_n && write_n && !busy;
    assign data_io_i = (data_io_o & ~data_io_oe_n) | (dq & data_io_oe_n);
    initial begin
        for (int i = 0; i < `SSA_DEPTH; i++) begin
            mem[i] = 8'h00;
            shadow[i] = 8'h00;
        end
        dq = 8'hA5;
        dirty = 1'b0;
        recall_req = 1'b1;
        busy = 1'b0;
        seq = 0;
    end
    // undriven byte flips so stale data never looks valid
    always @(addr_in or rd) begin
        seq++;
        dq = ~dq;
        fork
            automatic int s = seq;
            begin
                #(`SSA_SEL_ACCESS_NS);
                if (s == seq && rd) dq = mem[addr_in];
            end
        join_none
    end
    always @(posedge write_n or posedge sel_n) begin
        if ((sel_n === 1'b0 || write_n === 1'b0) && power_ok === 1'b1 && !busy) begin
            mem[addr_in] = data_io_i;
            dirty = 1'b1;
        end
    end
    always @(negedge power_ok) begin
        recall_req = 1'b1;
        #(`SSA_GRACE_US * 1000);
        if (dirty) begin
            shadow = mem;
            dirty = 1'b0;
        end
    end
    always @(posedge power_ok) begin
        if (recall_req) begin
            busy = 1'b1;
            #50;
            mem = shadow;
            recall_req = 1'b0;
            dirty = 1'b0;
            busy = 1'b0;
        end
    end
endmodule // ssa_device_model

// ### sim/ssa_host_test.sv
`timescale 1ns/1ps
`include "ssa_regs.svh"
module ssa_host_test;
    logic clk, rst, ce, req_valid, req_write, power_ok, ce_rand;
    logic [10:0] req_addr, a;
    logic [7:0] req_wdata;
    logic [15:0] lfsr_reg, ce_lfsr;
    wire logic req_ready, rsp_valid, mem_busy, sel_n, drive_n, write_n;
    wire logic [7:0] rsp_rdata, data_io_i, data_io_o, data_io_oe_n;
    wire logic [10:0] addr_in;
    logic [7:0] ref_mem [int];
    int n_fail, checks_done, k;
    ssa_host ssa_host_inst (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .power_ok(power_ok), .mem_busy(mem_busy), .sel_n(sel_n), .drive_n(drive_n),
        .write_n(write_n), .addr_in(addr_in), .data_io_i(data_io_i), .data_io_o(data_io_o),
        .data_io_oe_n(data_io_oe_n));
    ssa_device_model ssa_device_model_inst (.sel_n(sel_n), .drive_n(drive_n), .write_n(write_n),
        .addr_in(addr_in), .data_io_o(data_io_o), .data_io_oe_n(data_io_oe_n), .power_ok(power_ok),
        .data_io_i(data_io_i));
    always #5 clk = ~clk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge clk) begin
        if (ce_rand) begin
            ce_lfsr = lfsr_next(ce_lfsr);
            ce <= #1 ce_lfsr[0] | ce_lfsr[1];
        end
    end
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        checks_done++;
        if (seen !== expd) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic access(input logic wr, input logic [10:0] ad, input logic [7:0] d);
        int j;
        req_write = wr;
        req_addr = ad;
        req_wdata = d;
        req_valid = 1'b1;
        for (j = 0; j < 70000 && req_ready !== 1'b1; j++) step();
        req_valid = 1'b0;
        if (j == 70000) begin
            n_fail++;
            $display("wrong value at %0t: request not taken", $time);
            end_of_test();
        end
        for (j = 0; j < 100 && rsp_valid !== 1'b1; j++) step();
        if (j == 100) begin
            n_fail++;
            $display("wrong value at %0t: no answer", $time);
            end_of_test();
        end
        if (wr) ref_mem[ad] = d;
        else check(rsp_rdata, ref_mem.exists(ad) ? ref_mem[ad] : 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0; rst = 1'b1; ce = 1'b1; ce_rand = 1'b0; req_valid = 1'b0; req_write = 1'b0;
        req_addr = 11'h000; req_wdata = 8'h00; power_ok = 1'b1; n_fail = 0; checks_done = 0;
        lfsr_reg = 16'h004F; ce_lfsr = 16'h004F; a = 11'h000;
        repeat (6) step();
        rst = 1'b0;
        repeat (3) step();
        for (int i = 0; i < 20; i++) begin
            if (i == 12) ce_rand = 1'b1;
            lfsr_reg = lfsr_next(lfsr_reg);
            a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : lfsr_reg[10:0];
            access(1'b1, a, lfsr_reg[15:8]);
            access(1'b0, a, 8'h00);
        end
        ce_rand = 1'b0;
        step();
        ce = 1'b1;
        power_ok = 1'b0;
        for (k = 0; k < 10 && mem_busy !== 1'b1; k++) step();
        check({7'h00, mem_busy}, 8'h01);
        if (k == 10) end_of_test();
        req_valid = 1'b1;
        req_write = 1'b1;
        for (k = 0; k < 200; k++) begin
            step();
            check({6'h00, req_ready, write_n}, 8'h01);
        end
        req_valid = 1'b0;
        rst = 1'b1;
        repeat (6) step();
        rst = 1'b0;
        power_ok = 1'b1;
        for (k = 0; k < 10 && mem_busy !== 1'b1; k++) step();
        check({7'h00, mem_busy}, 8'h01);
        if (k == 10) end_of_test();
        for (k = 0; k < 60000 && mem_busy !== 1'b0; k++) step();
        check({7'h00, mem_busy}, 8'h00);
        if (k == 60000) end_of_test();
        foreach (ref_mem[key]) access(1'b0, key[10:0], 8'h00);
        end_of_test();
    end
endmodule // ssa_host_test
